// file: logic/prlk_pkg.sv
// Constants, types and register map of the pin routing unit and its controller
package prlk_pkg;

    localparam int NUM_PINS   = 48;
    localparam int NUM_INPUTS = 8;
    localparam int NUM_SRC    = 128;
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 8;

    // Device register map
    localparam logic [7:0] LOCK_OFF     = 8'h00;
    localparam logic [7:0] OUT_BASE_OFF = 8'h01;
    localparam logic [7:0] IN_BASE_OFF  = 8'h3E;
    localparam int         LOCK_BIT     = 0;
    localparam logic [7:0] KEY_FIRST    = 8'h55;
    localparam logic [7:0] KEY_SECOND   = 8'hAA;

    // Field layout of an input route, and the top source bit of an output route
    localparam int IN_PORT_HI = 5;
    localparam int IN_PORT_LO = 3;
    localparam int IN_PIN_HI  = 2;
    localparam int IN_PIN_LO  = 0;
    localparam int OUT_SRC_HI = 6;

    localparam logic [2:0] PORT_LAST = 3'h5;
    localparam logic [6:0] OUT_RESET = 7'h00;
    localparam logic [7:0] RD_RESET  = 8'h00;

    // Default pin for each peripheral input after a power reset: port B pins 0-7
    localparam logic [47:0] IN_DEFAULTS = {
        6'h0F, 6'h0E, 6'h0D, 6'h0C, 6'h0B, 6'h0A, 6'h09, 6'h08
    };

    // Controller register map
    localparam logic [2:0] CTL_CMD      = 3'h0;
    localparam logic [2:0] CTL_TARGET   = 3'h1;
    localparam logic [2:0] CTL_DATA     = 3'h2;
    localparam logic [2:0] CTL_STATUS   = 3'h3;
    localparam logic [2:0] CTL_READBACK = 3'h4;

    localparam logic [7:0] CMD_LOCK   = 8'h01;
    localparam logic [7:0] CMD_UNLOCK = 8'h02;
    localparam logic [7:0] CMD_WRITE  = 8'h03;
    localparam logic [7:0] CMD_READ   = 8'h04;

    localparam int ST_BUSY    = 0;
    localparam int ST_DONE    = 1;
    localparam int ST_REFUSED = 2;

    typedef enum logic [1:0] {
        KEY_IDLE = 2'b00,
        KEY_ONE  = 2'b01,
        KEY_TWO  = 2'b10
    } prlk_key_t;

    typedef enum logic [2:0] {
        CS_IDLE  = 3'b000,
        CS_KEY1  = 3'b001,
        CS_KEY2  = 3'b010,
        CS_FLAG  = 3'b011,
        CS_WRITE = 3'b100,
        CS_READ  = 3'b101,
        CS_CAPT  = 3'b110
    } prlk_cstate_t;

endpackage

// file: logic/prlk_if.sv
// Register access link between the routing controller and the routing unit
`timescale 1ns/1ps
interface prlk_if;
    logic [prlk_pkg::ADDR_W-1:0] addr;
    logic [prlk_pkg::DATA_W-1:0] wdata;
    logic                        wr;
    logic                        rd;
    logic [prlk_pkg::DATA_W-1:0] rdata;

    modport unit (input addr, input wdata, input wr, input rd, output rdata);
    modport ctrl (output addr, output wdata, output wr, output rd, input rdata);
endinterface

// file: logic/prlk_unit.sv
// Pin routing unit: input and output route registers, keyed lock, routing muxes
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module prlk_unit (
    input  wire logic                          ref_clk,
    input  wire logic                          rst,
    input  wire logic                          sys_reset,
    input  wire logic                          one_shot_lock_option,
    prlk_if.unit                               bus,
    input  wire logic [prlk_pkg::NUM_PINS-1:0] pin_in,
    input  wire logic [prlk_pkg::NUM_PINS-1:0] port_latch_value,
    input  wire logic [prlk_pkg::NUM_SRC-1:0]  periph_src,
    output logic      [prlk_pkg::NUM_PINS-1:0] pin_out,
    output logic      [prlk_pkg::NUM_INPUTS-1:0] periph_in,
    output logic                               routing_lock_flag
);
    import prlk_pkg::*;

    prlk_key_t  key_q;
    prlk_key_t  key_d;
    logic       lock_q;
    logic       lock_d;
    logic [6:0] out_route_q [NUM_PINS];
    logic [5:0] in_route_q  [NUM_INPUTS];
    logic [7:0] rdata_q;
    logic       lock_wr;
    logic       route_wr;
    logic       key_ok;
    logic       other_acc;
    logic       out_wr;
    logic       in_wr;
    logic [5:0] out_idx;
    logic [2:0] in_idx;
    logic [7:0] rd_value;

    function automatic logic is_out(input logic [7:0] a);
        return (a >= OUT_BASE_OFF) && (a < OUT_BASE_OFF + 8'(NUM_PINS));
    endfunction

    function automatic logic is_in(input logic [7:0] a);
        return (a >= IN_BASE_OFF) && (a < IN_BASE_OFF + 8'(NUM_INPUTS));
    endfunction

    function automatic logic [5:0] out_index(input logic [7:0] a);
        return 6'(a - OUT_BASE_OFF);
    endfunction

    function automatic logic [2:0] in_index(input logic [7:0] a);
        return 3'(a - IN_BASE_OFF);
    endfunction

    // Flat pin number of an input route: port times eight plus pin
    function automatic logic [5:0] pin_number(input logic [5:0] sel);
        return {sel[IN_PORT_HI:IN_PORT_LO], sel[IN_PIN_HI:IN_PIN_LO]};
    endfunction

    // Ports above the last one have no pins behind them
    function automatic logic port_valid(input logic [5:0] sel);
        return sel[IN_PORT_HI:IN_PORT_LO] <= PORT_LAST;
    endfunction

    // Code zero hands the pin back to its own port latch
    function automatic logic is_latch_code(input logic [6:0] code);
        return code == OUT_RESET;
    endfunction

    assign lock_wr   = bus.wr && (bus.addr == LOCK_OFF);
    assign key_ok    = lock_wr && (key_q == KEY_TWO);
    assign other_acc = (bus.wr || bus.rd) && !lock_wr;
    assign route_wr  = bus.wr && !lock_q;

    assign out_idx = out_index(bus.addr);
    assign in_idx  = in_index(bus.addr);
    assign out_wr  = route_wr && is_out(bus.addr);
    assign in_wr   = route_wr && is_in(bus.addr);

    // Key tracker: any other access in between breaks the sequence
    always_comb begin
        key_d = KEY_IDLE;
        if (lock_wr) begin
            case (key_q)
                KEY_IDLE: begin
                    if (bus.wdata == KEY_FIRST) begin
                        key_d = KEY_ONE;
                    end
                end
                KEY_ONE: begin
                    if (bus.wdata == KEY_SECOND) begin
                        key_d = KEY_TWO;
                    end else if (bus.wdata == KEY_FIRST) begin
                        key_d = KEY_ONE;
                    end
                end
                KEY_TWO: begin
                    // The flag write consumes the pair
                    key_d = KEY_IDLE;
                end
                default: key_d = KEY_IDLE;
            endcase
        end else if (!other_acc) begin
            key_d = key_q;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            key_q <= KEY_IDLE;
        end else if (sys_reset) begin
            key_q <= KEY_IDLE;
        end else begin
            key_q <= key_d;
        end
    end

    // Lock flag honours a flag write only straight after the key pair
    always_comb begin
        lock_d = lock_q;
        if (key_ok) begin
            if (bus.wdata[LOCK_BIT]) begin
                lock_d = 1'b1;
            end else if (!one_shot_lock_option) begin
                lock_d = 1'b0;
            end else begin
                // One-shot option: a set flag stays until reset
                lock_d = lock_q;
            end
        end
    end

    // Every reset type clears the flag; the routes survive a system reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lock_q <= 1'b0;
        end else if (sys_reset) begin
            lock_q <= 1'b0;
        end else begin
            lock_q <= lock_d;
        end
    end

    assign routing_lock_flag = lock_q;

    // Selections reset only on power reset; no sleep or system reset term
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_PINS; i++) begin
                out_route_q[i] <= OUT_RESET;
            end
        end else if (out_wr) begin
            out_route_q[out_idx] <= bus.wdata[OUT_SRC_HI:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_INPUTS; i++) begin
                in_route_q[i] <= IN_DEFAULTS[i*6 +: 6];
            end
        end else if (in_wr) begin
            in_route_q[in_idx] <= bus.wdata[IN_PORT_HI:0];
        end
    end

    // Value of the addressed register; unmapped addresses read zero
    always_comb begin
        rd_value = RD_RESET;
        if (bus.addr == LOCK_OFF) begin
            rd_value = {7'h00, lock_q};
        end else if (is_out(bus.addr)) begin
            rd_value = {1'b0, out_route_q[out_idx]};
        end else if (is_in(bus.addr)) begin
            rd_value = {2'b00, in_route_q[in_idx]};
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= RD_RESET;
        end else if (bus.rd) begin
            rdata_q <= rd_value;
        end else begin
            rdata_q <= RD_RESET;
        end
    end

    assign bus.rdata = rdata_q;

    // Output routing, code zero gives the port latch
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            if (is_latch_code(out_route_q[i])) begin
                pin_out[i] = port_latch_value[i];
            end else begin
                pin_out[i] = periph_src[out_route_q[i]];
            end
        end
    end

    // Input routing: port times eight plus pin; ports above F read low
    always_comb begin
        for (int j = 0; j < NUM_INPUTS; j++) begin
            if (port_valid(in_route_q[j])) begin
                periph_in[j] = pin_in[pin_number(in_route_q[j])];
            end else begin
                periph_in[j] = 1'b0;
            end
        end
    end

endmodule

// file: logic/prlk_ctrl.sv
// Routing controller: runs keyed lock sequences and route accesses from its own registers
`timescale 1ns/1ps
module prlk_ctrl (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic [2:0] cmd_addr,
    input  wire logic [7:0] cmd_wdata,
    input  wire logic       cmd_wr,
    input  wire logic       cmd_rd,
    output logic      [7:0] cmd_rdata,
    prlk_if.ctrl            bus
);
    import prlk_pkg::*;

    prlk_cstate_t state_q;
    prlk_cstate_t state_d;
    logic [7:0]   target_q;
    logic [7:0]   data_q;
    logic [7:0]   readback_q;
    logic [7:0]   rdata_q;
    logic         done_q;
    logic         refused_q;
    logic         busy;
    logic         cmd_go;

    assign busy   = (state_q != CS_IDLE);
    assign cmd_go = cmd_wr && (cmd_addr == CTL_CMD);

    always_comb begin
        state_d = state_q;
        case (state_q)
            CS_IDLE: begin
                if (cmd_go) begin
                    case (cmd_wdata)
                        CMD_LOCK:   state_d = CS_KEY1;
                        CMD_UNLOCK: state_d = CS_KEY1;
                        CMD_WRITE:  state_d = CS_WRITE;
                        CMD_READ:   state_d = CS_READ;
                        default:    state_d = CS_IDLE;
                    endcase
                end
            end
            CS_KEY1:  state_d = CS_KEY2;
            CS_KEY2:  state_d = CS_FLAG;
            CS_FLAG:  state_d = CS_IDLE;
            CS_WRITE: state_d = CS_IDLE;
            CS_READ:  state_d = CS_CAPT;
            CS_CAPT:  state_d = CS_IDLE;
            default:  state_d = CS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= CS_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Lock or unlock is remembered in data_q bit 0 during the sequence
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            target_q <= 8'h00;
            data_q   <= 8'h00;
        end else if (!busy && cmd_go && cmd_wdata == CMD_LOCK) begin
            data_q <= 8'h01;
        end else if (!busy && cmd_go && cmd_wdata == CMD_UNLOCK) begin
            data_q <= 8'h00;
        end else if (!busy && cmd_wr && cmd_addr == CTL_TARGET) begin
            target_q <= cmd_wdata;
        end else if (!busy && cmd_wr && cmd_addr == CTL_DATA) begin
            data_q <= cmd_wdata;
        end
    end

    // Bus strobes follow the state; sequence writes run back to back
    always_comb begin
        bus.wr    = 1'b0;
        bus.rd    = 1'b0;
        bus.addr  = LOCK_OFF;
        bus.wdata = 8'h00;
        case (state_q)
            CS_KEY1: begin
                bus.wr    = 1'b1;
                bus.wdata = KEY_FIRST;
            end
            CS_KEY2: begin
                bus.wr    = 1'b1;
                bus.wdata = KEY_SECOND;
            end
            CS_FLAG: begin
                bus.wr    = 1'b1;
                bus.wdata = data_q;
            end
            CS_WRITE: begin
                bus.wr    = 1'b1;
                bus.addr  = target_q;
                bus.wdata = data_q;
            end
            CS_READ: begin
                bus.rd   = 1'b1;
                bus.addr = target_q;
            end
            default: bus.wr = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            readback_q <= 8'h00;
        end else if (state_q == CS_CAPT) begin
            readback_q <= bus.rdata;
        end
    end

    // Sticky status bits: the setting event wins over a write-one clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            done_q <= 1'b0;
        end else if (busy && state_d == CS_IDLE) begin
            done_q <= 1'b1;
        end else if (cmd_wr && cmd_addr == CTL_STATUS && cmd_wdata[ST_DONE]) begin
            done_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            refused_q <= 1'b0;
        end else if (busy && cmd_wr && cmd_addr != CTL_STATUS) begin
            refused_q <= 1'b1;
        end else if (cmd_wr && cmd_addr == CTL_STATUS && cmd_wdata[ST_REFUSED]) begin
            refused_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (cmd_rd) begin
            case (cmd_addr)
                CTL_TARGET:   rdata_q <= target_q;
                CTL_DATA:     rdata_q <= data_q;
                CTL_STATUS:   rdata_q <= {5'h00, refused_q, done_q, busy};
                CTL_READBACK: rdata_q <= readback_q;
                default:      rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign cmd_rdata = rdata_q;

endmodule

// file: test/prlk_properties.sv
// Concurrent checks on the register link between controller and routing unit
`timescale 1ns/1ps
module prlk_properties (
    input wire logic                        ref_clk,
    input wire logic                        rst,
    input wire logic                        sys_reset,
    input wire logic                        one_shot_lock_option,
    input wire logic [prlk_pkg::ADDR_W-1:0] addr,
    input wire logic [prlk_pkg::DATA_W-1:0] wdata,
    input wire logic                        wr,
    input wire logic                        rd,
    input wire logic [prlk_pkg::DATA_W-1:0] rdata,
    input wire logic                        routing_lock_flag
);
    import prlk_pkg::*;
    prlk_key_t key_q;
    prlk_key_t key_d;
    logic      lock_wr;
    logic      set_ok;
    logic      clr_ok;
    assign lock_wr = wr && addr == LOCK_OFF;
    assign set_ok = key_q == KEY_TWO && lock_wr && wdata[LOCK_BIT];
    assign clr_ok = key_q == KEY_TWO && lock_wr && !wdata[LOCK_BIT] && !one_shot_lock_option;
    // Reference key tracker: any other access drops it back to idle
    always_comb begin
        key_d = key_q;
        if (sys_reset) begin
            key_d = KEY_IDLE;
        end else if (wr || rd) begin
            if (lock_wr && wdata == KEY_FIRST && key_q != KEY_TWO) begin
                key_d = KEY_ONE;
            end else if (lock_wr && wdata == KEY_SECOND && key_q == KEY_ONE) begin
                key_d = KEY_TWO;
            end else begin
                key_d = KEY_IDLE;
            end
        end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            key_q <= KEY_IDLE;
        end else begin
            key_q <= key_d;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    chk_key_order: assert property (lock_wr && wdata == KEY_FIRST |=>
        lock_wr && wdata == KEY_SECOND ##1 lock_wr) else $error("key writes not back to back");
    chk_key_pace: assert property (lock_wr && wdata == KEY_SECOND |->
        $past(lock_wr) && $past(wdata) == KEY_FIRST) else $error("key pair split");
    chk_lock_set: assert property (set_ok && !sys_reset |=> routing_lock_flag)
        else $error("keyed set not taken");
    chk_lock_clear: assert property (clr_ok && !sys_reset |=> !routing_lock_flag)
        else $error("keyed clear not taken");
    chk_no_set: assert property (!routing_lock_flag && !set_ok |=> !routing_lock_flag)
        else $error("flag set without key");
    chk_no_clear: assert property (routing_lock_flag && !sys_reset && !clr_ok
        |=> routing_lock_flag) else $error("flag cleared without key");
    chk_one_shot: assert property (one_shot_lock_option && routing_lock_flag
        && !sys_reset |=> $stable(routing_lock_flag)) else $error("one shot flag cleared");
    chk_sys_clear: assert property (sys_reset |=> !routing_lock_flag)
        else $error("reset left flag set");
    chk_read_lock: assert property (rd && addr == LOCK_OFF |=>
        rdata == {7'h00, $past(routing_lock_flag)}) else $error("lock readback wrong");
endmodule

// file: test/tb_peripheral_pin_routing_lock.sv
// Testbench: routing controller and routing unit joined across the register link
`timescale 1ns/1ps
module tb_peripheral_pin_routing_lock;
    import prlk_pkg::*;
    logic         ref_clk = 1'b0;
    logic         rst = 1'b1;
    logic         sys_reset = 1'b0;
    logic         one_shot = 1'b0;
    logic [2:0]   cmd_addr = 3'h0;
    logic [7:0]   cmd_wdata = 8'h00;
    logic         cmd_wr = 1'b0;
    logic         cmd_rd = 1'b0;
    logic [7:0]   cmd_rdata;
    logic [47:0]  pin_in = 48'hA5C3_0F96_5A3C;
    logic [47:0]  latch = 48'h1234_5678_9ABC;
    logic [127:0] src = {4{32'hC0DE_F00D}};
    logic [47:0]  pin_out;
    logic [7:0]   periph_in;
    logic         lock;
    logic [7:0]   rv;
    int           err_total = 0;
    int           checks = 0;
    prlk_if bus ();
    always #2.5 ref_clk = ~ref_clk;
    prlk_unit u_prlk_unit (.ref_clk(ref_clk), .rst(rst), .sys_reset(sys_reset),
        .one_shot_lock_option(one_shot), .bus(bus), .pin_in(pin_in),
        .port_latch_value(latch), .periph_src(src), .pin_out(pin_out),
        .periph_in(periph_in), .routing_lock_flag(lock));
    prlk_ctrl u_prlk_ctrl (.ref_clk(ref_clk), .rst(rst), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata),
        .bus(bus));
    prlk_properties u_prlk_properties (.ref_clk(ref_clk), .rst(rst), .sys_reset(sys_reset),
        .one_shot_lock_option(one_shot), .addr(bus.addr), .wdata(bus.wdata), .wr(bus.wr),
        .rd(bus.rd), .rdata(bus.rdata), .routing_lock_flag(lock));
    task automatic final_report();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cwr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        cmd_wr <= 1'b1;
        cmd_addr <= a;
        cmd_wdata <= d;
        @(posedge ref_clk);
        cmd_wr <= 1'b0;
    endtask
    task automatic crd(input logic [2:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        cmd_rd <= 1'b1;
        cmd_addr <= a;
        @(posedge ref_clk);
        cmd_rd <= 1'b0;
        #1 d = cmd_rdata;
    endtask
    // Issue a command and poll until idle; it must end done and not refused
    task automatic run(input logic [7:0] c);
        int n;
        cwr(CTL_CMD, c);
        n = 0;
        rv = 8'h01;
        while (rv[ST_BUSY] !== 1'b0 && n < 20) begin
            crd(CTL_STATUS, rv);
            n++;
        end
        chk(rv & 8'h07, 8'h02);
        cwr(CTL_STATUS, 8'h07);
    endtask
    task automatic dwr(input logic [7:0] t, input logic [7:0] d);
        cwr(CTL_TARGET, t);
        cwr(CTL_DATA, d);
        run(CMD_WRITE);
    endtask
    task automatic drd(input logic [7:0] t, input logic [7:0] exp);
        cwr(CTL_TARGET, t);
        run(CMD_READ);
        crd(CTL_READBACK, rv);
        chk(rv, exp);
    endtask
    task automatic t_reset();
        chk({7'h00, lock}, 8'h00);
        for (int j = 0; j < 6; j++) begin
            chk(pin_out[j*8+:8], latch[j*8+:8]);
        end
        for (int i = 0; i < 8; i++) begin
            chk({7'h00, periph_in[i]}, {7'h00, pin_in[8+i]});
            drd(IN_BASE_OFF + 8'(i), 8'h08 + 8'(i));
        end
        drd(OUT_BASE_OFF, 8'h00);
    endtask
    task automatic t_route();
        for (int p = 0; p < 6; p++) begin
            dwr(IN_BASE_OFF, 8'(p * 8 + 7 - p));
            chk({7'h00, periph_in[0]}, {7'h00, pin_in[p*8+7-p]});
        end
        dwr(OUT_BASE_OFF, 8'h22);
        chk({7'h00, pin_out[0]}, {7'h00, src[34]});
        dwr(IN_BASE_OFF + 8'h01, 8'h00);
        chk({7'h00, periph_in[1]}, {7'h00, pin_in[0]});
        dwr(IN_BASE_OFF + 8'h03, 8'h30);
        chk({7'h00, periph_in[3]}, 8'h00);
        drd(IN_BASE_OFF + 8'h03, 8'h30);
        dwr(OUT_BASE_OFF + 8'h01, 8'hFF);
        chk({7'h00, pin_out[1]}, {7'h00, src[127]});
        drd(OUT_BASE_OFF + 8'h01, 8'h7F);
    endtask
    // Controller: unknown codes ignored, writes refused while a sequence runs
    task automatic t_ctrl();
        cwr(CTL_TARGET, 8'h3F);
        crd(CTL_TARGET, rv);
        chk(rv, 8'h3F);
        cwr(CTL_CMD, 8'h07);
        crd(CTL_STATUS, rv);
        chk(rv, 8'h00);
        cwr(CTL_CMD, CMD_UNLOCK);
        cwr(CTL_DATA, 8'h5A);
        repeat (4) @(posedge ref_clk);
        crd(CTL_STATUS, rv);
        chk(rv, 8'h06);
        crd(CTL_DATA, rv);
        chk(rv, 8'h00);
        chk({7'h00, lock}, 8'h00);
        cwr(CTL_STATUS, 8'h07);
        crd(CTL_STATUS, rv);
        chk(rv, 8'h00);
    endtask
    task automatic t_lock();
        dwr(LOCK_OFF, 8'h01);
        chk({7'h00, lock}, 8'h00);
        for (int k = 0; k < 2; k++) begin
            run(CMD_LOCK);
            chk({7'h00, lock}, 8'h01);
            drd(LOCK_OFF, 8'h01);
            dwr(IN_BASE_OFF, 8'h01);
            drd(IN_BASE_OFF, 8'h2A);
            run(CMD_UNLOCK);
            chk({7'h00, lock}, 8'h00);
            dwr(IN_BASE_OFF, 8'h2A - 8'(k));
        end
        drd(IN_BASE_OFF, 8'h29);
    endtask
    task automatic t_oneshot();
        one_shot <= 1'b1;
        run(CMD_LOCK);
        run(CMD_UNLOCK);
        chk({7'h00, lock}, 8'h01);
        @(posedge ref_clk);
        sys_reset <= 1'b1;
        @(posedge ref_clk);
        sys_reset <= 1'b0;
        #1 chk({7'h00, lock}, 8'h00);
        drd(IN_BASE_OFF, 8'h29);
        drd(OUT_BASE_OFF, 8'h22);
        run(CMD_LOCK);
        chk({7'h00, lock}, 8'h01);
        one_shot <= 1'b0;
    endtask
    task automatic t_power();
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_route();
        t_ctrl();
        t_lock();
        t_oneshot();
        t_power();
        final_report();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        final_report();
    end
endmodule
